// ### rtl/serial_ctrl.v
`timescale 1ns/1ps
`include "serial_map.vh"
module serial_ctrl (
    input wire i_clk, // System clock 10 MHz
    input wire i_nrst, // Async reset, low
    input wire [2:0] i_addr, // Register address
    input wire [7:0] i_wdata, // Write data
    input wire i_wr, // Write strobe
    input wire i_rd, // Read strobe
    input wire i_clk_off, // Serial clock switched off
    input wire i_rx, // RX pin level
    output reg [7:0] o_rdata, // Read data, cycle after strobe
    output reg o_tx, // TX pin output
    output reg o_tx_oe, // TX pin drive enable
    output reg o_irq, // Interrupt request flag
    output reg o_wake // Wake-up request
);
    ////////////////////////////////////////////////////////////////////
    // Registers
    reg en_ff, len_ff, pen_ff, ptype_ff, stop_ff, brk_ff, rx8_ff, tx8_ff;
    reg [7:0] ctrl2_ff;
    reg [7:0] div_ff;
    reg [7:0] txr_ff, rxr_ff;
    reg tx_holding_empty_ff, tx_idle_flag_ff, rx_data_available_ff, rx_idle_flag_ff, overrun_flag_ff, framing_error_flag_ff, parity_error_flag_ff, nf_ff;
    reg stat_read_ff; // Status read arms the clear sequence
    reg rx_prev_ff;
    wire transmitter_enable = ctrl2_ff[`C2_TRANSMITTER_ENABLE];
    wire receiver_enable = ctrl2_ff[`C2_RECEIVER_ENABLE];
    wire tx_on = en_ff & transmitter_enable;
    wire rx_on = en_ff & receiver_enable;
    wire wr_ctrl1 = i_wr && i_addr == `ADDR_CTRL1;
    wire dis_now = wr_ctrl1 && !i_wdata[`C1_EN];
    wire wr_data = i_wr && i_addr == `ADDR_DATA;
    wire rd_data = i_rd && i_addr == `ADDR_DATA;
    ////////////////////////////////////////////////////////////////////
    // Transmitter state
    localparam TX_IDLE = 2'd0;
    localparam TX_SHIFT = 2'd1;
    localparam TX_BREAK = 2'd2;
    reg [1:0] tx_st_ff;
    reg [11:0] tx_sh_ff;
    reg [3:0] tx_cnt_ff;
    wire tx_tick;
    wire tx_busy = tx_st_ff != TX_IDLE;
    baud_tick u_tx_tick (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_run(tx_on && (tx_busy || !tx_holding_empty_ff || brk_ff)),
        .i_restart(1'b0),
        .i_high_speed(ctrl2_ff[`C2_HS]),
        .i_divisor(div_ff),
        .o_tick(tx_tick)
    );
    // Data bits with optional parity replacing last slot
    wire [8:0] tx_word = {tx8_ff, txr_ff};
    reg [8:0] tx_data;
    reg [3:0] tx_len;
    always @*
    begin
        tx_data = tx_word;
        tx_len = len_ff ? 4'd9 : 4'd8;
        if (pen_ff)
        begin
            if (len_ff)
                tx_data[8] = ^tx_word[7:0] ^ ptype_ff;
            else
                tx_data[7] = ^tx_word[6:0] ^ ptype_ff;
        end
    end
    // Frame: start, data, stop_bit_count, ones beyond frame length
    wire [11:0] tx_frame = len_ff ? {2'b11, tx_data, 1'b0}
                                  : {3'b111, tx_data[7:0], 1'b0};
    wire [3:0] tx_bits = 4'd2 + tx_len + {3'd0, stop_ff};
    ////////////////////////////////////////////////////////////////////
    // Receiver state
    localparam RX_IDLE = 2'd0;
    localparam RX_SHIFT = 2'd1;
    reg [1:0] rx_st_ff;
    reg [9:0] rx_sh_ff;
    reg [3:0] rx_cnt_ff;
    wire rx_tick;
    wire rx_fall = rx_prev_ff & ~i_rx;
    wire rx_start = rx_on && rx_st_ff == RX_IDLE && rx_fall;
    // Restart on the start edge puts every tick mid-bit
    baud_tick u_rx_tick (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_run(rx_on && rx_st_ff != RX_IDLE),
        .i_restart(rx_start),
        .i_high_speed(ctrl2_ff[`C2_HS]),
        .i_divisor(div_ff),
        .o_tick(rx_tick)
    );
    wire [3:0] rx_len = len_ff ? 4'd9 : 4'd8;
    wire rx_last = rx_tick && rx_cnt_ff == rx_len + 4'd1;
    // Word as received: data bits then the first stop in bit 9
    wire [9:0] rx_word = len_ff ? {i_rx, rx_sh_ff[9:1]} : {i_rx, rx_sh_ff[9:2], 1'b0};
    wire [8:0] rx_data = len_ff ? rx_word[8:0] : {1'b0, rx_word[8:1]};
    wire rx_par_bad = pen_ff && ((^rx_data[8:0]) ^ ptype_ff) == 1'b0 ? 1'b0 : pen_ff;
    wire rx_addr_bit = len_ff ? rx_data[8] : rx_data[7];
    wire rx_keep = !ctrl2_ff[`C2_ADDR] || rx_addr_bit;
    ////////////////////////////////////////////////////////////////////
    // Register writes, flags, and the disable side effects
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            {en_ff, len_ff, pen_ff, ptype_ff, stop_ff, brk_ff, rx8_ff, tx8_ff} <= `CTRL_RESET;
            ctrl2_ff <= `CTRL_RESET;
            div_ff <= `DIV_RESET;
            txr_ff <= 8'h00;
            rxr_ff <= 8'h00;
            {tx_holding_empty_ff, tx_idle_flag_ff, rx_idle_flag_ff} <= 3'b111;
            {rx_data_available_ff, overrun_flag_ff, framing_error_flag_ff, parity_error_flag_ff, nf_ff} <= 5'b00000;
            stat_read_ff <= 1'b0;
            tx_st_ff <= TX_IDLE;
            tx_sh_ff <= 12'hFFF;
            tx_cnt_ff <= 4'h0;
            rx_st_ff <= RX_IDLE;
            rx_sh_ff <= 10'h000;
            rx_cnt_ff <= 4'h0;
            rx_prev_ff <= 1'b1;
            o_tx <= 1'b1;
        end
        else
        begin
            rx_prev_ff <= i_rx;
            if (i_rd)
                stat_read_ff <= (i_addr == `ADDR_STATUS);
            else if (i_wr)
                stat_read_ff <= 1'b0;
            if (wr_ctrl1)
                {en_ff, len_ff, pen_ff, ptype_ff, stop_ff, brk_ff, tx8_ff} <=
                    {i_wdata[7:2], i_wdata[`C1_TX8]};
            if (i_wr && i_addr == `ADDR_CTRL2)
                ctrl2_ff <= i_wdata;
            if (i_wr && i_addr == `ADDR_DIVISOR)
                div_ff <= i_wdata;
            // Status clear sequence: status read, then data access
            if (stat_read_ff && (rd_data || wr_data))
                {overrun_flag_ff, framing_error_flag_ff, parity_error_flag_ff, nf_ff} <= 4'b0000;
            if (stat_read_ff && rd_data)
                rx_data_available_ff <= 1'b0;
            if (wr_data)
            begin
                txr_ff <= i_wdata;
                if (stat_read_ff)
                    {tx_holding_empty_ff, tx_idle_flag_ff} <= 2'b00;
            end
            // Transmitter
            case (tx_st_ff)
                TX_IDLE:
                    if (tx_tick && !tx_holding_empty_ff)
                    begin
                        tx_sh_ff <= {1'b1, tx_frame[11:1]};
                        o_tx <= 1'b0;
                        tx_cnt_ff <= tx_bits - 4'd1;
                        tx_st_ff <= TX_SHIFT;
                        tx_holding_empty_ff <= 1'b1; // Holding register drained
                    end
                    else if (tx_tick && brk_ff)
                    begin
                        o_tx <= 1'b0;
                        tx_cnt_ff <= `BREAK_BITS - 4'd1;
                        tx_st_ff <= TX_BREAK;
                        tx_idle_flag_ff <= 1'b0;
                    end
                    else if (tx_holding_empty_ff && !brk_ff && !(wr_data && stat_read_ff))
                        tx_idle_flag_ff <= 1'b1;
                TX_SHIFT:
                    if (tx_tick)
                    begin
                        o_tx <= tx_sh_ff[0];
                        tx_sh_ff <= {1'b1, tx_sh_ff[11:1]};
                        tx_cnt_ff <= tx_cnt_ff - 4'd1;
                        if (tx_cnt_ff == 4'd0)
                        begin
                            o_tx <= 1'b1;
                            tx_st_ff <= TX_IDLE;
                        end
                    end
                TX_BREAK:
                    if (tx_tick)
                    begin
                        if (tx_cnt_ff != 4'd0)
                            tx_cnt_ff <= tx_cnt_ff - 4'd1;
                        else if (!brk_ff)
                        begin
                            o_tx <= 1'b1;
                            tx_st_ff <= TX_IDLE;
                        end
                    end
                default:
                    tx_st_ff <= TX_IDLE;
            endcase
            // Receiver
            case (rx_st_ff)
                RX_IDLE:
                    if (rx_start)
                    begin
                        rx_st_ff <= RX_SHIFT;
                        rx_cnt_ff <= 4'd0;
                        rx_idle_flag_ff <= 1'b0;
                    end
                RX_SHIFT:
                    if (rx_tick)
                    begin
                        if (rx_cnt_ff == 4'd0 && i_rx)
                        begin
                            rx_st_ff <= RX_IDLE; // False start
                            rx_idle_flag_ff <= 1'b1;
                        end
                        else
                        begin
                            rx_sh_ff <= {i_rx, rx_sh_ff[9:1]};
                            rx_cnt_ff <= rx_cnt_ff + 4'd1;
                        end
                        if (rx_last)
                        begin
                            rx_st_ff <= RX_IDLE;
                            rx_idle_flag_ff <= 1'b1;
                            if (rx_keep)
                            begin
                                if (rx_data_available_ff)
                                    overrun_flag_ff <= 1'b1; // Overrun keeps old data
                                else
                                begin
                                    rx_data_available_ff <= 1'b1;
                                    rxr_ff <= rx_data[7:0];
                                    if (len_ff && !pen_ff)
                                        rx8_ff <= rx_data[8];
                                    framing_error_flag_ff <= ~i_rx;
                                    parity_error_flag_ff <= rx_par_bad;
                                end
                            end
                        end
                    end
                default:
                    rx_st_ff <= RX_IDLE;
            endcase
            // Transmitter or receiver disable aborts its side
            if (!tx_on || (i_wr && i_addr == `ADDR_CTRL2 && !i_wdata[`C2_TRANSMITTER_ENABLE]))
            begin
                tx_st_ff <= TX_IDLE;
                tx_sh_ff <= 12'hFFF;
                o_tx <= 1'b1;
            end
            if (!rx_on || (i_wr && i_addr == `ADDR_CTRL2 && !i_wdata[`C2_RECEIVER_ENABLE]))
            begin
                rx_st_ff <= RX_IDLE;
                rx_cnt_ff <= 4'h0;
                rx_idle_flag_ff <= 1'b1;
            end
            // Global disable resets flags and buffer, keeps setup
            if (dis_now || !en_ff)
            begin
                ctrl2_ff[`C2_TRANSMITTER_ENABLE] <= 1'b0;
                ctrl2_ff[`C2_RECEIVER_ENABLE] <= 1'b0;
                brk_ff <= 1'b0;
                {rx_data_available_ff, overrun_flag_ff, framing_error_flag_ff, parity_error_flag_ff, nf_ff} <= 5'b00000;
                {tx_holding_empty_ff, tx_idle_flag_ff, rx_idle_flag_ff} <= 3'b111;
                tx_st_ff <= TX_IDLE;
                rx_st_ff <= RX_IDLE;
                o_tx <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Pins, interrupt, wake, read port
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_tx_oe <= 1'b0;
            o_irq <= 1'b0;
            o_wake <= 1'b0;
            o_rdata <= 8'h00;
        end
        else
        begin
            o_tx_oe <= tx_on && !dis_now;
            // Level request while any enabled source holds
            o_irq <= (ctrl2_ff[`C2_RIE] && (rx_data_available_ff || overrun_flag_ff))
                || (ctrl2_ff[`C2_TX_IDLE_IRQ_ENABLE] && tx_idle_flag_ff)
                || (ctrl2_ff[`C2_TX_EMPTY_IRQ_ENABLE] && tx_holding_empty_ff)
                || o_wake;
            // Wake only when the serial clock is stopped
            if (i_clk_off && ctrl2_ff[`C2_WAKE] && rx_fall)
                o_wake <= 1'b1;
            else if (!i_clk_off || !ctrl2_ff[`C2_WAKE])
                o_wake <= 1'b0;
            o_rdata <= 8'h00;
            if (i_rd)
                case (i_addr)
                    `ADDR_CTRL1: o_rdata <= {en_ff, len_ff, pen_ff, ptype_ff, stop_ff,
                                             brk_ff, rx8_ff, 1'b0};
                    `ADDR_CTRL2: o_rdata <= ctrl2_ff;
                    `ADDR_STATUS: o_rdata <= {parity_error_flag_ff, nf_ff, framing_error_flag_ff, overrun_flag_ff,
                                              rx_idle_flag_ff, rx_data_available_ff, tx_idle_flag_ff, tx_holding_empty_ff};
                    `ADDR_DATA: o_rdata <= rxr_ff;
                    `ADDR_DIVISOR: o_rdata <= div_ff;
                    default: o_rdata <= 8'h00;
                endcase
        end
    end
    // Noise detection is not modelled; its flag only clears
endmodule // serial_ctrl

// ### rtl/serial_map.vh
// Function
// - Global enable off floats both pins
// - Disable empties buffer, resets baud counter
// - Disable clears flags, sets idle flags
// - Disable aborts activity; re-enable keeps configuration
// - Length bit selects eight or nine bits
// - Parity occupies last data slot, not stored; in eight-bit mode the code keeps it in bit 7 of the data register
// - Parity enable on; type odd when set
// - Stop select gives one or two stop_bit_count
// - Break after data, low thirteen bits minimum
// - Rx ninth bit read only; tx write only
// - Transmitter disable aborts, resets, floats TX
// - TX driven only with both enables
// - Receiver disable aborts, resets, floats RX
// - RX used only with both enables; the wake detector watches RX edges without them
// - Speed bit selects high or low mode
// - Address bit set word is address, interrupts
// - Address bit clear word discarded silently
// - Wake edge only while clock off
// - Rx enable gates overrun and available
// - Idle enable gates tx idle flag
// - Empty enable gates tx empty flag
// - Idle needs empty and nothing sending
// - Rate clock over 64 or 16 times N+1
// - Start low, data lsb first, stop_bit_count
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH
`define ADDR_CTRL1 3'h0
`define ADDR_CTRL2 3'h1
`define ADDR_STATUS 3'h2
`define ADDR_DATA 3'h3
`define ADDR_DIVISOR 3'h4
`define C1_EN 7
`define C1_LEN 6
`define C1_PEN 5
`define C1_PTYPE 4
`define C1_STOP 3
`define C1_BRK 2
`define C1_RX8 1
`define C1_TX8 0
`define C2_TRANSMITTER_ENABLE 7
`define C2_RECEIVER_ENABLE 6
`define C2_HS 5
`define C2_ADDR 4
`define C2_WAKE 3
`define C2_RIE 2
`define C2_TX_IDLE_IRQ_ENABLE 1
`define C2_TX_EMPTY_IRQ_ENABLE 0
`define CTRL_RESET 8'h00
`define DIV_RESET 8'h00
`define OSR_LOW 7'h40
`define OSR_HIGH 7'h10
`define BREAK_BITS 4'hD
`endif

// ### rtl/baud_tick.v
`timescale 1ns/1ps
`include "serial_map.vh"
// Bit-rate tick: one pulse per bit time, cleared when disabled
module baud_tick (
    input wire i_clk, // System clock
    input wire i_nrst, // Async reset, low
    input wire i_run, // Counters run
    input wire i_restart, // Realign to a bit edge
    input wire i_high_speed, // Speed select
    input wire [7:0] i_divisor, // N
    output reg o_tick // Bit-time pulse
);
    reg [7:0] pre_ff;
    reg [6:0] osr_ff;
    wire [6:0] osr_top = i_high_speed ? `OSR_HIGH : `OSR_LOW;
    // Divide by (N+1) then by 64 or 16
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pre_ff <= 8'h00;
            osr_ff <= 7'h00;
            o_tick <= 1'b0;
        end
        else if (i_restart)
        begin
            // Start half way so the first tick falls mid-bit
            pre_ff <= 8'h00;
            osr_ff <= osr_top >> 1;
            o_tick <= 1'b0;
        end
        else if (!i_run)
        begin
            pre_ff <= 8'h00;
            osr_ff <= 7'h00;
            o_tick <= 1'b0;
        end
        else
        begin
            o_tick <= 1'b0;
            if (pre_ff == i_divisor)
            begin
                pre_ff <= 8'h00;
                if (osr_ff == osr_top - 7'h01)
                begin
                    osr_ff <= 7'h00;
                    o_tick <= 1'b1;
                end
                else
                    osr_ff <= osr_ff + 7'h01;
            end
            else
                pre_ff <= pre_ff + 8'h01;
        end
    end
endmodule // baud_tick

// ### dv/serial_ctrl_chk.sv
`timescale 1ns/1ps
module serial_ctrl_chk (
    input wire i_clk, // Clock
    input wire i_nrst, // Reset, low
    input wire [2:0] i_addr, // Address
    input wire [7:0] i_wdata, // Write data
    input wire i_wr, // Write strobe
    input wire i_rd, // Read strobe
    input wire i_clk_off, // Clock off
    input wire i_rx, // RX level
    input wire [7:0] o_rdata, // Read data
    input wire o_tx, // TX level
    input wire o_tx_oe, // TX drive
    input wire o_irq, // Request
    input wire o_wake // Wake
);
reg en_ff;
reg up_ff;
reg [7:0] c2_ff;
wire transmitter_enable_w = c2_ff[7];
wire irq_off = ~|c2_ff[2:0];
// Shadow of the enables; a disable also drops both side enables
always @(posedge i_clk or negedge i_nrst)
begin
    if (!i_nrst)
    begin
        en_ff <= 1'h0;
        up_ff <= 1'h0;
        c2_ff <= 8'h00;
    end
    else
    begin
        up_ff <= 1'h1;
        if (i_wr && i_addr == 3'h0)
        begin
            en_ff <= i_wdata[7];
            if (!i_wdata[7])
                c2_ff[7:6] <= 2'h0;
        end
        else if (i_wr && i_addr == 3'h1)
            c2_ff <= i_wdata;
    end
end
default clocking @(posedge i_clk); endclocking
default disable iff (!i_nrst);
////////////////////////////////////////////////////////////////////////////////
disable_float_a: assert property (i_wr && i_addr == 3'h0 && !i_wdata[7] |-> ##[1:3] !o_tx_oe)
    else $error("TX still driven after disable");
transmitter_enable_drive_a: assert property (en_ff && i_wr && i_addr == 3'h1 && i_wdata[7] |-> ##[1:3] o_tx_oe)
    else $error("TX not driven after enable");
oe_cause_a: assert property (o_tx_oe |-> $past(en_ff) && $past(transmitter_enable_w))
    else $error("TX driven without both enables");
idle_high_a: assert property (up_ff && !en_ff && !$past(en_ff) && !$past(en_ff, 2)
    |-> o_tx && !o_tx_oe)
    else $error("TX not released while disabled");
tx8_hidden_a: assert property ($past(i_rd) && $past(i_addr) == 3'h0 |-> !o_rdata[0])
    else $error("Write-only ninth bit readable");
ctrl2_keep_a: assert property ($past(i_rd) && $past(i_addr) == 3'h1 |-> o_rdata == $past(c2_ff))
    else $error("Control two readback wrong");
wake_cause_a: assert property ($rose(o_wake) |-> c2_ff[3] && $past(i_clk_off))
    else $error("Wake without wake bit and clock off");
irq_quiet_a: assert property (irq_off && $past(irq_off) && !o_wake && !$past(o_wake) |-> !o_irq)
    else $error("Request with all sources masked");
wake_c: cover property ($rose(o_wake));
irq_c: cover property ($rose(o_irq));
oe_off_c: cover property ($fell(o_tx_oe));
endmodule // serial_ctrl_chk
bind serial_ctrl serial_ctrl_chk chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_clk_off(i_clk_off), .i_rx(i_rx),
    .o_rdata(o_rdata), .o_tx(o_tx), .o_tx_oe(o_tx_oe), .o_irq(o_irq), .o_wake(o_wake));

// ### dv/remote_serial.sv
`timescale 1ns/1ps
// Far-side transceiver; TX line idles high through a pull-up, RX line is driven high
module remote_serial (
    input wire i_clk, // System clock
    input wire i_line, // Resolved TX wire
    output reg o_line // RX wire drive
);
initial o_line = 1'h1;
// Bits go out lsb first, then the line is let go high
task send(input [11:0] bits, input integer n, input integer per);
    integer i;
    begin
        for (i = 0; i < n; i = i + 1)
        begin
            o_line <= bits[i];
            repeat (per) @(posedge i_clk);
        end
        o_line <= 1'h1;
    end
endtask
// Sampling mid-bit tolerates a start edge found a few cycles late
task capture(output [11:0] bits, input integer n, input integer per, output reg ok);
    integer i;
    integer t;
    begin
        bits = 12'h000;
        t = 0;
        while (i_line && t < 4 * per)
        begin
            @(posedge i_clk);
            t = t + 1;
        end
        ok = !i_line;
        repeat (per / 2) @(posedge i_clk);
        for (i = 0; i < n; i = i + 1)
        begin
            bits[i] = i_line;
            repeat (per) @(posedge i_clk);
        end
    end
endtask
endmodule // remote_serial

// ### dv/uart_control_registers_test.sv
`timescale 1ns/1ps
module uart_control_registers_test;
reg clk = 1'h0;
reg nrst = 1'h0;
reg [2:0] addr = 3'h0;
reg [7:0] wdata = 8'h00;
reg wr = 1'h0;
reg rd = 1'h0;
reg clk_off = 1'h0;
wire rx_line;
wire [7:0] rdata;
wire tx;
wire tx_oe;
wire irq;
wire wake;
wire tx_line = tx_oe ? tx : 1'h1;
integer err_total = 0;
integer n_tests = 0;
always #50 clk = ~clk;
serial_ctrl dut (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_clk_off(clk_off), .i_rx(rx_line), .o_rdata(rdata), .o_tx(tx),
    .o_tx_oe(tx_oe), .o_irq(irq), .o_wake(wake));
remote_serial partner (.i_clk(clk), .i_line(tx_line), .o_line(rx_line));
////////////////////////////////////////////////////////////////////////////////
task final_report;
    begin
        $display("compares %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
endtask
task check(input [15:0] seen, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
endtask
// Bus cycles: one strobe cycle, data sampled in the cycle after
task wr_reg(input [2:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    end
endtask
task rd_reg(input [2:0] a, output [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    end
endtask
task rd_chk(input [2:0] a, input [7:0] m, input [7:0] e);
    reg [7:0] d;
    begin
        rd_reg(a, d);
        check(d & m, e);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
// One transmitted frame, expected bits built from the format fields
task tx_case(input [7:0] c1, input [7:0] c2, input [7:0] dv, input [7:0] data, input integer ns);
    reg [8:0] f;
    reg [11:0] exp;
    reg [11:0] got;
    reg [7:0] d;
    reg ok;
    integer nd;
    integer per;
    integer i;
    begin
        nd = c1[6] ? 9 : 8;
        per = (c2[5] ? 16 : 64) * (dv + 1);
        f = {c1[0], data};
        if (c1[5])
            f[nd - 1] = ^(f & ((9'h001 << (nd - 1)) - 9'h001)) ^ c1[4];
        exp = 12'h000;
        for (i = 0; i < nd + ns; i = i + 1)
            exp[i + 1] = (i < nd) ? f[i] : 1'h1;
        wr_reg(3'h4, dv);
        wr_reg(3'h0, c1);
        wr_reg(3'h1, c2);
        rd_reg(3'h2, d);
        wr_reg(3'h3, data);
        rd_chk(3'h2, 8'h02, 8'h00);
        partner.capture(got, nd + ns + 1, per, ok);
        check(ok, 1);
        check(got, exp);
        repeat (per) @(posedge clk);
        rd_chk(3'h2, 8'h03, 8'h03);
    end
endtask
// One received frame; status, request and data judged after it
task rx_case(input [7:0] c2, input [11:0] bits, input [7:0] st, input ie, input [7:0] dx);
    begin
        wr_reg(3'h1, c2);
        partner.send(bits, 10, 16);
        repeat (32) @(posedge clk);
        check(irq, ie);
        rd_chk(3'h2, 8'h24, st);
        if (st[2])
        begin
            rd_chk(3'h3, 8'hFF, dx);
            repeat (3) @(posedge clk);
            check(irq, 0);
        end
    end
endtask
task irq_chk(input [7:0] c2, input e);
    begin
        wr_reg(3'h1, c2);
        repeat (3) @(posedge clk);
        check(irq, e);
    end
endtask
task t_break;
    reg bad;
    integer t;
    begin
        wr_reg(3'h0, 8'h84);
        t = 0;
        while (tx_line && t < 64)
        begin
            @(posedge clk);
            t = t + 1;
        end
        bad = tx_line;
        repeat (13 * 16 + 32) @(posedge clk) bad = bad | tx_line;
        check(bad, 0);
        wr_reg(3'h0, 8'h80);
        repeat (48) @(posedge clk);
        check(tx_line, 1);
    end
endtask
// Disable mid-frame: pins released, flags reset, config kept, nothing resent
task t_disable;
    reg [7:0] d;
    reg bad;
    begin
        wr_reg(3'h1, 8'hA0);
        rd_reg(3'h2, d);
        wr_reg(3'h3, 8'h00);
        repeat (40) @(posedge clk);
        wr_reg(3'h0, 8'h00);
        repeat (3) @(posedge clk);
        check(tx_oe, 0);
        rd_chk(3'h2, 8'hFF, 8'h0B);
        rd_chk(3'h1, 8'hFF, 8'h20);
        wr_reg(3'h0, 8'h80);
        rd_chk(3'h1, 8'hFF, 8'h20);
        check(tx_oe, 0);
        wr_reg(3'h1, 8'hA0);
        bad = 1'h0;
        repeat (64) @(posedge clk) bad = bad | !tx_line;
        check(bad, 0);
        check(tx_oe, 1);
    end
endtask
task t_wake;
    begin
        wr_reg(3'h1, 8'h08);
        partner.send(12'h000, 1, 8);
        repeat (4) @(posedge clk);
        check(wake, 0);
        clk_off <= 1'h1;
        partner.send(12'h000, 1, 8);
        repeat (4) @(posedge clk);
        check(wake, 1);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    rd_chk(3'h0, 8'hFD, 8'h00);
    rd_chk(3'h1, 8'hFF, 8'h00);
    rd_chk(3'h2, 8'hFF, 8'h0B);
    wr_reg(3'h5, 8'hFF);
    rd_chk(3'h5, 8'hFF, 8'h00);
    check(tx_oe, 0);
    $display("reset test done");
    wr_reg(3'h0, 8'h80);
    wr_reg(3'h1, 8'h80);
    rd_chk(3'h2, 8'hFF, 8'h0B);
    check(tx_oe, 1);
    tx_case(8'h80, 8'h80, 8'h00, 8'hA5, 1);
    tx_case(8'hB8, 8'hA0, 8'h01, 8'h35, 2);
    tx_case(8'hC1, 8'h80, 8'h00, 8'h3C, 1);
    tx_case(8'hE0, 8'hA0, 8'h00, 8'h5A, 1);
    $display("transmit test done");
    t_break;
    $display("break test done");
    rx_case(8'hE4, {1'h1, 8'hC3, 1'h0}, 8'h04, 1, 8'hC3);
    rx_case(8'hE4, {1'h0, 8'h3C, 1'h0}, 8'h24, 1, 8'h3C);
    rx_case(8'hF4, {1'h1, 8'h05, 1'h0}, 8'h00, 0, 8'h00);
    rx_case(8'hF4, {1'h1, 8'h85, 1'h0}, 8'h04, 1, 8'h85);
    $display("receive test done");
    irq_chk(8'h81, 1);
    irq_chk(8'h82, 1);
    irq_chk(8'h80, 0);
    $display("request test done");
    t_disable;
    $display("disable test done");
    t_wake;
    $display("wake test done");
    final_report;
end
// Watchdog, well beyond the roughly four thousand cycles the tests need
initial
begin
    repeat (40000) @(posedge clk);
    err_total = err_total + 1;
    final_report;
end
endmodule // uart_control_registers_test
